// [verilog/mii_timing_pkg.sv]
/*
  Shared constants for the MAC-side receive and transmit timing logic:
  clock rate, bit times, latency figures, clock phase lengths and modes.
  Assumes a single system clock of 200 MHz.
*/
package mii_timing_pkg;

  // ****************************************
  // Clock and bit times
  // ****************************************
  localparam int CLK_NS = 5;
  localparam int BIT_FAST_NS = 10;
  localparam int BIT_SLOW_NS = 100;

  typedef logic [7:0] cnt_t;

  // Least time: round up, never below one cycle
  function automatic cnt_t cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return cnt_t'(c);
  endfunction

  // Longest time: round down, never below one cycle
  function automatic cnt_t cyc_max(input int ns);
    int c;
    c = ns / CLK_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return cnt_t'(c);
  endfunction

  // ****************************************
  // Receive latencies
  // ****************************************
  localparam int CRS_ON_TX_BITS = 20;
  localparam int DATA_TX_BITS = 24;
  localparam int CRS_ON_FX_BITS = 10;
  localparam int DATA_FX_BITS = 14;
  localparam int CRS_OFF_TX_BITS = 24;
  localparam int CRS_OFF_FX_BITS = 14;
  localparam int DV_10T_BITS = 10;
  localparam int DATA_10T_BITS = 8;
  localparam int CRS_ON_10T_NS = 630;
  localparam int CRS_ON_10T_MAX_NS = 1000;
  localparam int CRS_OFF_10T_MAX_NS = 1000;
  localparam int CRS_OFF_10T_NS = 800;

  localparam cnt_t CRS_ON_TX_CYC = cyc_min(CRS_ON_TX_BITS * BIT_FAST_NS);
  localparam cnt_t DATA_TX_CYC = cyc_min(DATA_TX_BITS * BIT_FAST_NS);
  localparam cnt_t CRS_ON_FX_CYC = cyc_min(CRS_ON_FX_BITS * BIT_FAST_NS);
  localparam cnt_t DATA_FX_CYC = cyc_min(DATA_FX_BITS * BIT_FAST_NS);
  localparam cnt_t CRS_OFF_TX_CYC = cyc_min(CRS_OFF_TX_BITS * BIT_FAST_NS);
  localparam cnt_t CRS_OFF_FX_CYC = cyc_min(CRS_OFF_FX_BITS * BIT_FAST_NS);
  localparam cnt_t DV_10T_CYC = cyc_min(DV_10T_BITS * BIT_SLOW_NS);
  localparam cnt_t DATA_10T_CYC = cyc_min(DATA_10T_BITS * BIT_SLOW_NS);
  localparam cnt_t CRS_ON_10T_CYC = cyc_min(CRS_ON_10T_NS);
  localparam cnt_t CRS_OFF_10T_CYC = cyc_max(CRS_OFF_10T_NS);

  // ****************************************
  // Clock phase lengths
  // ****************************************
  localparam int MII100_HALF_NS = 20;
  localparam int MII10_HALF_NS = 200;
  localparam int SER_TX_HIGH_NS = 25;
  localparam int SER_TX_LOW_NS = 75;
  localparam int SER_RX_HALF_NS = 50;

  localparam cnt_t MII100_HALF_CYC = cyc_min(MII100_HALF_NS);
  localparam cnt_t MII10_HALF_CYC = cyc_min(MII10_HALF_NS);
  localparam cnt_t SER_TX_HIGH_CYC = cyc_min(SER_TX_HIGH_NS);
  localparam cnt_t SER_TX_LOW_CYC = cyc_min(SER_TX_LOW_NS);
  localparam cnt_t SER_RX_HALF_CYC = cyc_min(SER_RX_HALF_NS);

  // ****************************************
  // Data path and modes
  // ****************************************
  localparam int DLY_DEPTH = 256;
  localparam int DLY_AW = 8;
  localparam int NIB_W = 4;
  localparam int DLY_W = NIB_W + 1;

  typedef enum logic [1:0] {
    MODE_100TX = 2'b00,
    MODE_100FX = 2'b01,
    MODE_10T_MII = 2'b10,
    MODE_10T_SER = 2'b11
  } link_mode_e;

endpackage

// [verilog/phase_clock_gen.sv]
/*
  Divided clock generator: high and low phase lengths in system cycles,
  rise and fall enable pulses, optional parking at one level.
  Assumes phase lengths change only while the link mode changes.
*/
`timescale 1ns/1ps
module phase_clock_gen
  import mii_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Phase control
  input wire mii_timing_pkg::cnt_t high_cyc_in,
  input wire mii_timing_pkg::cnt_t low_cyc_in,
  input wire logic park_in,
  input wire logic park_level_in,
  // Clock and edge enables
  output logic clk_out,
  output logic rise_out,
  output logic fall_out
);

  typedef struct packed {
    logic level;
    cnt_t cnt;
    logic rise;
    logic fall;
  } gen_s;

  gen_s st_reg;
  gen_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.rise = 1'b0;
    st_next.fall = 1'b0;
    if (st_reg.cnt > cnt_t'(1))
    begin
      st_next.cnt = st_reg.cnt - cnt_t'(1);
    end
    else if (!(park_in && (st_reg.level == park_level_in)))
    begin
      // Parking only stretches a phase that has already run its full length
      st_next.level = ~st_reg.level;
      st_next.rise = ~st_reg.level;
      st_next.fall = st_reg.level;
      st_next.cnt = st_reg.level ? low_cyc_in : high_cyc_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg <= '{level: 1'b0, cnt: cnt_t'(1), rise: 1'b0, fall: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign clk_out = st_reg.level;
  assign rise_out = st_reg.rise;
  assign fall_out = st_reg.fall;

endmodule

// [verilog/tap_delay_line.sv]
/*
  Variable delay line: a ring of words, read a selected number of
  cycles behind the write point. Output is registered.
  Assumes the delay select stays below the depth.
*/
`timescale 1ns/1ps
module tap_delay_line
  import mii_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Data and tap
  input wire logic [DLY_W-1:0] data_in,
  input wire mii_timing_pkg::cnt_t delay_in,
  output logic [DLY_W-1:0] data_out
);

  typedef struct packed {
    logic [DLY_AW-1:0] wptr;
    cnt_t fill;
    logic [DLY_W-1:0] dout;
  } dly_s;

  logic [DLY_W-1:0] ring [DLY_DEPTH];
  dly_s st_reg;
  dly_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.wptr = st_reg.wptr + DLY_AW'(1);
    if (st_reg.fill != '1)
    begin
      st_next.fill = st_reg.fill + cnt_t'(1);
    end
    // One cycle of the tap is spent in the output register
    if (st_reg.fill >= delay_in)
    begin
      st_next.dout = ring[st_reg.wptr - DLY_AW'(delay_in) + DLY_AW'(1)];
    end
    else
    begin
      // Words not yet written since reset read as idle, so valid never goes unknown
      st_next.dout = '0;
    end
  end

  // Ring contents need no reset; unwritten words are masked by the fill count
  always_ff @(posedge clk_in)
  begin
    ring[st_reg.wptr] <= data_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign data_out = st_reg.dout;

endmodule

// [verilog/mii_latency_core.sv]
/*
  MAC-side data interface timing of one transceiver port: sources the
  transmit and receive clocks, samples the MAC's transmit signals on the
  right edge, and delays carrier sense, receive data valid and receive
  data by the latencies of each line mode.
  Assumes the line-side decoder runs on the system clock and marks the
  first bit of the start and end code groups, line activity and the
  start-frame delimiter with same-clock signals.
*/
// Functional notes
// - 100TX: carrier 20, data 24 bits
// - 100FX: carrier 10, data 14 bits
// - Carrier drops 24/14 bits after end
// - Fast bit time is 10 ns
// - 10M nibble: sample on clock fall
// - Nibble: receive clock may stretch low
// - Serial: receive clock may stretch high
// - Serial: sample on rise, 25/75 ns clock
// - Serial: receive outputs change on fall
// - 10BASE-T: valid 10 bits after preamble
// - 10BASE-T: data 8 bits after delimiter
// - 10BASE-T: carrier on 630 ns, under 1000
// - 10BASE-T: carrier off within 1 us
`timescale 1ns/1ps
module mii_latency_core
  import mii_timing_pkg::*;
(
  // System clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // Configuration
  input wire mii_timing_pkg::link_mode_e MODE_IN,
  input wire logic RX_CLK_SWITCH_IN,
  // Line-side receive events
  input wire logic LINE_ACT_IN,
  input wire logic LINE_SSD_IN,
  input wire logic LINE_ESD_IN,
  input wire logic LINE_SFD_IN,
  input wire logic LINE_VALID_IN,
  input wire logic [NIB_W-1:0] LINE_DATA_IN,
  // Line-side transmit data
  output logic [NIB_W-1:0] LINE_TXD_OUT,
  output logic LINE_TX_EN_OUT,
  output logic LINE_TX_STB_OUT,
  // MAC transmit pins
  output logic TX_CLK_OUT,
  input wire logic [NIB_W-1:0] TXD_IN,
  input wire logic TX_EN_IN,
  // MAC receive pins
  output logic RX_CLK_OUT,
  output logic [NIB_W-1:0] RXD_OUT,
  output logic RX_DV_OUT,
  output logic CRS_OUT
);

  // ****************************************
  // Mode decoding
  // ****************************************
  function automatic logic is_fast(input link_mode_e m);
    return (m == MODE_100TX) || (m == MODE_100FX);
  endfunction

  function automatic logic is_serial(input link_mode_e m);
    return m == MODE_10T_SER;
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NIB_W-1:0] txd_s1;
    logic [NIB_W-1:0] txd_s2;
    logic tx_en_s1;
    logic tx_en_s2;
    logic [NIB_W-1:0] line_txd;
    logic line_tx_en;
    logic line_tx_stb;
    logic act_d;
    logic crs;
    logic crs_rising;
    cnt_t crs_cnt;
    logic dv10;
    cnt_t dv_cnt;
    logic dly_valid_d;
    logic [NIB_W-1:0] rxd;
    logic rx_dv;
  } core_s;

  core_s st_reg;
  core_s st_next;

  logic fast;
  logic serial;
  logic tx_rise;
  logic tx_fall;
  logic rx_fall;
  logic tx_sample;
  logic act_rise;
  logic act_fall;
  cnt_t tx_high;
  cnt_t tx_low;
  cnt_t rx_half;
  cnt_t data_dly;
  logic [DLY_W-1:0] dly_out;
  logic dly_valid;

  assign fast = is_fast(MODE_IN);
  assign serial = is_serial(MODE_IN);
  assign act_rise = LINE_ACT_IN && !st_reg.act_d;
  assign act_fall = !LINE_ACT_IN && st_reg.act_d;
  assign dly_valid = dly_out[DLY_W-1];

  // ****************************************
  // Clock phases per mode
  // ****************************************
  always_comb
  begin
    case (MODE_IN)
      MODE_100TX, MODE_100FX:
      begin
        tx_high = MII100_HALF_CYC;
        tx_low = MII100_HALF_CYC;
        rx_half = MII100_HALF_CYC;
      end
      MODE_10T_MII:
      begin
        tx_high = MII10_HALF_CYC;
        tx_low = MII10_HALF_CYC;
        rx_half = MII10_HALF_CYC;
      end
      MODE_10T_SER:
      begin
        tx_high = SER_TX_HIGH_CYC;
        tx_low = SER_TX_LOW_CYC;
        rx_half = SER_RX_HALF_CYC;
      end
      default:
      begin
        tx_high = MII100_HALF_CYC;
        tx_low = MII100_HALF_CYC;
        rx_half = MII100_HALF_CYC;
      end
    endcase
  end

  // ****************************************
  // Receive data latency per mode
  // ****************************************
  always_comb
  begin
    case (MODE_IN)
      MODE_100TX:
      begin
        data_dly = DATA_TX_CYC;
      end
      MODE_100FX:
      begin
        data_dly = DATA_FX_CYC;
      end
      default:
      begin
        data_dly = DATA_10T_CYC;
      end
    endcase
  end

  // ****************************************
  // Clock sources and receive delay line
  // ****************************************
  phase_clock_gen u_tx_clk (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .high_cyc_in(tx_high),
    .low_cyc_in(tx_low),
    .park_in(1'b0),
    .park_level_in(1'b0),
    .clk_out(TX_CLK_OUT),
    .rise_out(tx_rise),
    .fall_out(tx_fall)
  );

  // Switching between reference and recovered clock parks the receive
  // clock low in nibble modes and high in serial mode
  phase_clock_gen u_rx_clk (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .high_cyc_in(rx_half),
    .low_cyc_in(rx_half),
    .park_in(RX_CLK_SWITCH_IN),
    .park_level_in(serial),
    .clk_out(RX_CLK_OUT),
    .rise_out(),
    .fall_out(rx_fall)
  );

  tap_delay_line u_rx_dly (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .data_in({LINE_VALID_IN, LINE_DATA_IN}),
    .delay_in(data_dly),
    .data_out(dly_out)
  );

  // ****************************************
  // Transmit sampling edge
  // ****************************************
  // The MAC launches on the rise, so the 10M nibble mode samples half a
  // period later; the pin synchroniser costs two cycles of the setup
  assign tx_sample = (MODE_IN == MODE_10T_MII) ? tx_fall : tx_rise;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.txd_s1 = TXD_IN;
    st_next.txd_s2 = st_reg.txd_s1;
    st_next.tx_en_s1 = TX_EN_IN;
    st_next.tx_en_s2 = st_reg.tx_en_s1;
    st_next.act_d = LINE_ACT_IN;
    st_next.dly_valid_d = dly_valid;
    st_next.line_tx_stb = 1'b0;

    if (tx_sample)
    begin
      // Serial mode carries its single data bit on lane 0
      st_next.line_txd = serial ? {{(NIB_W-1){1'b0}}, st_reg.txd_s2[0]} : st_reg.txd_s2;
      st_next.line_tx_en = st_reg.tx_en_s2;
      st_next.line_tx_stb = 1'b1;
    end

    // Carrier timer: counts down, acts when it reaches one
    if (st_reg.crs_cnt > cnt_t'(1))
    begin
      st_next.crs_cnt = st_reg.crs_cnt - cnt_t'(1);
    end
    else if (st_reg.crs_cnt == cnt_t'(1))
    begin
      st_next.crs_cnt = '0;
      st_next.crs = st_reg.crs_rising;
    end

    if (fast)
    begin
      if (LINE_SSD_IN)
      begin
        st_next.crs_rising = 1'b1;
        st_next.crs_cnt = (MODE_IN == MODE_100TX) ? CRS_ON_TX_CYC : CRS_ON_FX_CYC;
      end
      else if (LINE_ESD_IN)
      begin
        st_next.crs_rising = 1'b0;
        st_next.crs_cnt = (MODE_IN == MODE_100TX) ? CRS_OFF_TX_CYC : CRS_OFF_FX_CYC;
      end
    end
    else
    begin
      if (act_rise)
      begin
        st_next.crs_rising = 1'b1;
        st_next.crs_cnt = CRS_ON_10T_CYC;
      end
      else if (act_fall)
      begin
        st_next.crs_rising = 1'b0;
        st_next.crs_cnt = CRS_OFF_10T_CYC;
      end
    end

    // Slow-mode valid timer from the first preamble bit
    if (st_reg.dv_cnt > cnt_t'(1))
    begin
      st_next.dv_cnt = st_reg.dv_cnt - cnt_t'(1);
    end
    else if (st_reg.dv_cnt == cnt_t'(1))
    begin
      st_next.dv_cnt = '0;
      st_next.dv10 = 1'b1;
    end
    if (!fast && act_rise)
    begin
      st_next.dv_cnt = DV_10T_CYC;
    end
    // Valid ends when the delayed frame runs out
    if (st_reg.dly_valid_d && !dly_valid && (st_reg.dv_cnt == '0))
    begin
      st_next.dv10 = 1'b0;
    end
    if (fast)
    begin
      st_next.dv10 = 1'b0;
      st_next.dv_cnt = '0;
    end

    // Receive outputs change only at the receive clock fall
    if (rx_fall)
    begin
      st_next.rxd = serial ? {{(NIB_W-1){1'b0}}, dly_out[0]} : dly_out[NIB_W-1:0];
      st_next.rx_dv = fast ? dly_valid : st_reg.dv10;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign LINE_TXD_OUT = st_reg.line_txd;
  assign LINE_TX_EN_OUT = st_reg.line_tx_en;
  assign LINE_TX_STB_OUT = st_reg.line_tx_stb;
  assign RXD_OUT = st_reg.rxd;
  assign RX_DV_OUT = st_reg.rx_dv;
  assign CRS_OUT = st_reg.crs;

endmodule

// [dv/mii_latency_checker.sv]
/*
  Port timing checker for mii_latency_core.
  Sees only the top ports; bound to every instance.
*/
`timescale 1ns/1ps
module mii_latency_checker
  import mii_timing_pkg::*;
(
  // Clock, reset, mode
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire mii_timing_pkg::link_mode_e MODE_IN,
  // Line side
  input wire logic LINE_ACT_IN,
  input wire logic LINE_SSD_IN,
  input wire logic LINE_ESD_IN,
  input wire logic LINE_TX_EN_OUT,
  input wire logic LINE_TX_STB_OUT,
  // MAC side
  input wire logic TX_CLK_OUT,
  input wire logic TX_EN_IN,
  input wire logic RX_CLK_OUT,
  input wire logic [NIB_W-1:0] RXD_OUT,
  input wire logic RX_DV_OUT,
  input wire logic CRS_OUT
);
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);

  // ****************************************
  // Properties
  // ****************************************
  // One cycle of slack: the register lands one edge after the count ends
  sequence s_crs_up;
    !CRS_OUT ##[1:2] CRS_OUT;
  endsequence
  sequence s_crs_down;
    CRS_OUT ##[1:2] !CRS_OUT;
  endsequence
  property p_on_tx;
    MODE_IN == MODE_100TX && LINE_SSD_IN && !CRS_OUT |-> ##39 s_crs_up;
  endproperty
  property p_on_fx;
    MODE_IN == MODE_100FX && LINE_SSD_IN && !CRS_OUT |-> ##19 s_crs_up;
  endproperty
  property p_off_tx;
    MODE_IN == MODE_100TX && LINE_ESD_IN && !LINE_SSD_IN && CRS_OUT |-> ##47 s_crs_down;
  endproperty
  property p_off_fx;
    MODE_IN == MODE_100FX && LINE_ESD_IN && !LINE_SSD_IN && CRS_OUT |-> ##27 s_crs_down;
  endproperty
  property p_on_10m;
    MODE_IN[1] && $rose(LINE_ACT_IN) && !CRS_OUT |-> ##[1:200] CRS_OUT;
  endproperty
  property p_off_10m;
    MODE_IN[1] && $fell(LINE_ACT_IN) && CRS_OUT |-> ##[1:201] !CRS_OUT;
  endproperty
  property p_tx_fall;
    MODE_IN == MODE_10T_MII && $stable(MODE_IN)
      |-> LINE_TX_STB_OUT == (!$past(TX_CLK_OUT) && $past(TX_CLK_OUT, 2));
  endproperty
  property p_tx_rise;
    MODE_IN == MODE_10T_SER && $stable(MODE_IN)
      |-> LINE_TX_STB_OUT == ($past(TX_CLK_OUT) && !$past(TX_CLK_OUT, 2));
  endproperty
  property p_tx_en;
    LINE_TX_STB_OUT |-> LINE_TX_EN_OUT == $past(TX_EN_IN, 3);
  endproperty
  property p_ser_clk;
    MODE_IN == MODE_10T_SER && $stable(MODE_IN) && $rose(TX_CLK_OUT)
      |-> TX_CLK_OUT[*5] ##1 !TX_CLK_OUT[*8];
  endproperty
  property p_rx_upd;
    $changed(RXD_OUT) || $changed(RX_DV_OUT) |-> !RX_CLK_OUT && $past(RX_CLK_OUT, 2);
  endproperty
  property p_nib_low;
    MODE_IN == MODE_10T_MII && $stable(MODE_IN) && $fell(RX_CLK_OUT) |-> !RX_CLK_OUT[*8];
  endproperty

  a_on_tx: assert property (p_on_tx) else $error("carrier on timing, 100TX");
  a_on_fx: assert property (p_on_fx) else $error("carrier on timing, 100FX");
  a_off_tx: assert property (p_off_tx) else $error("carrier off timing, 100TX");
  a_off_fx: assert property (p_off_fx) else $error("carrier off timing, 100FX");
  a_on_10m: assert property (p_on_10m) else $error("carrier on late, 10M");
  a_off_10m: assert property (p_off_10m) else $error("carrier off late, 10M");
  a_tx_fall: assert property (p_tx_fall) else $error("nibble sample edge");
  a_tx_rise: assert property (p_tx_rise) else $error("serial sample edge");
  a_tx_en: assert property (p_tx_en) else $error("sampled enable wrong");
  a_ser_clk: assert property (p_ser_clk) else $error("serial transmit clock phases");
  a_rx_upd: assert property (p_rx_upd) else $error("receive outputs off the fall");
  a_nib_low: assert property (p_nib_low) else $error("receive clock low too short");
endmodule

bind mii_latency_core mii_latency_checker u_chk (.CLK_SYS_IN, .RST_IN, .MODE_IN, .LINE_ACT_IN,
  .LINE_SSD_IN, .LINE_ESD_IN, .LINE_TX_EN_OUT, .LINE_TX_STB_OUT, .TX_CLK_OUT, .TX_EN_IN,
  .RX_CLK_OUT, .RXD_OUT, .RX_DV_OUT, .CRS_OUT);

// [dv/mac_tx_model.sv]
/*
  MAC transmit model: launches a new nibble on one edge of the
  transceiver's transmit clock. Assumes the bench picks that edge.
*/
`timescale 1ns/1ps
module mac_tx_model
(
  input wire logic clk_in,
  input wire logic tx_clk_in,
  input wire logic run_in,
  input wire logic launch_rise_in,
  output logic [3:0] txd_out,
  output logic tx_en_out
);
  logic last_reg = 1'b0;

  initial
  begin
    txd_out = 4'h0;
    tx_en_out = 1'b0;
  end

  // ****************************************
  // Launch
  // ****************************************
  // Opposite edge to the sampling one gives half a period of setup in nibble mode, the 75 ns low phase in serial mode
  // The clock output settles at the system edge, so look just after it
  always @(posedge clk_in)
  begin
    #1;
    if (tx_clk_in !== last_reg && tx_clk_in === launch_rise_in)
    begin
      txd_out = txd_out + 4'h3;
      tx_en_out = run_in;
    end
    last_reg = tx_clk_in;
  end
endmodule

// [dv/tb.sv]
/*
  Self-checking bench for mii_latency_core.
  Assumes the package constants and the hand-over timing.
*/
`timescale 1ns/1ps
module tb;
  import mii_timing_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  link_mode_e mode = MODE_100TX;
  logic sw = 1'b0;
  logic act = 1'b0;
  logic ssd = 1'b0;
  logic esd = 1'b0;
  logic vld = 1'b0;
  logic [3:0] ldat = 4'h0;
  logic run = 1'b0;
  logic on_rise = 1'b1;
  logic [3:0] ltxd, txd, rxd, got_rxd;
  logic ltx_en, stb, tx_clk, tx_en, rx_clk, dv, crs;
  int fail_count = 0;
  int n_compared = 0;

  always #2.5 clk = ~clk;

  mii_latency_core DUT (.CLK_SYS_IN(clk), .RST_IN(rst), .MODE_IN(mode), .RX_CLK_SWITCH_IN(sw),
    .LINE_ACT_IN(act), .LINE_SSD_IN(ssd), .LINE_ESD_IN(esd), .LINE_SFD_IN(1'b0),
    .LINE_VALID_IN(vld), .LINE_DATA_IN(ldat), .LINE_TXD_OUT(ltxd), .LINE_TX_EN_OUT(ltx_en),
    .LINE_TX_STB_OUT(stb), .TX_CLK_OUT(tx_clk), .TXD_IN(txd), .TX_EN_IN(tx_en),
    .RX_CLK_OUT(rx_clk), .RXD_OUT(rxd), .RX_DV_OUT(dv), .CRS_OUT(crs));

  mac_tx_model u_mac (.clk_in(clk), .tx_clk_in(tx_clk), .run_in(run),
    .launch_rise_in(on_rise), .txd_out(txd), .tx_en_out(tx_en));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_rng(input string what, input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("ERROR t=%0t %s: %0d cycles, want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic chk4(input string what, input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t %s: %h, want %h", $time, what, got, exp);
    end
  endtask

  // Cycles until carrier and valid reach lvl; a spent bound ends the run
  task automatic watch(input logic lvl, output int nc, output int nd);
    nc = -1;
    nd = -1;
    for (int n = 0; n <= 300 && (nc < 0 || nd < 0); n++)
    begin
      if (nc < 0 && crs === lvl)
        nc = n;
      if (nd < 0 && dv === lvl)
        nd = n;
      got_rxd = rxd;
      step(1);
    end
    if (nc < 0 || nd < 0)
    begin
      fail_count++;
      $display("ERROR t=%0t wait ran out", $time);
      stop_test();
    end
  endtask

  task automatic set_mode(input link_mode_e m);
    mode = m;
    step(100);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_fast(input link_mode_e m, input int on_b, input int off_b, input int dat_b);
    int nc, nd;
    set_mode(m);
    vld = 1'b1;
    ldat = 4'h5;
    ssd = 1'b1;
    step(1);
    ssd = 1'b0;
    watch(1'b1, nc, nd);
    chk_rng("carrier on", nc, on_b * 2, on_b * 2 + 1);
    chk_rng("data valid", nd, dat_b * 2, dat_b * 2 + 10);
    chk4("receive nibble", got_rxd, 4'h5);
    vld = 1'b0;
    esd = 1'b1;
    step(1);
    esd = 1'b0;
    watch(1'b0, nc, nd);
    chk_rng("carrier off", nc, off_b * 2, off_b * 2 + 1);
  endtask

  task automatic sc_slow(input link_mode_e m, input int half);
    int nc, nd;
    set_mode(m);
    vld = 1'b1;
    ldat = 4'h5;
    act = 1'b1;
    step(1);
    watch(1'b1, nc, nd);
    chk_rng("carrier on", nc, CRS_ON_10T_NS / CLK_NS, CRS_ON_10T_MAX_NS / CLK_NS);
    chk_rng("data valid", nd, 200, 200 + 2 * half + 2);
    chk4("receive data", got_rxd, m == MODE_10T_SER ? 4'h1 : 4'h5);
    vld = 1'b0;
    act = 1'b0;
    step(1);
    watch(1'b0, nc, nd);
    chk_rng("carrier off", nc, 1, 200);
  endtask

  task automatic sc_tx(input link_mode_e m, input logic rise);
    int k;
    set_mode(m);
    on_rise = rise;
    run = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      k = 0;
      while (stb !== 1'b1 && k < 200)
      begin
        step(1);
        k++;
      end
      chk_rng("strobe wait", k, 0, 199);
      if (k >= 200)
      begin
        stop_test();
      end
      chk4("sample edge", {3'b000, tx_clk}, {3'b000, ~rise});
      chk4("sampled data", ltxd, m == MODE_10T_SER ? {3'b000, txd[0]} : txd);
      chk4("sampled enable", {3'b000, ltx_en}, {3'b000, tx_en});
      step(1);
    end
    run = 1'b0;
  endtask

  task automatic sc_park(input link_mode_e m, input logic lvl);
    set_mode(m);
    sw = 1'b1;
    step(100);
    chk4("parked clock", {3'b000, rx_clk}, {3'b000, lvl});
    step(50);
    chk4("still parked", {3'b000, rx_clk}, {3'b000, lvl});
    sw = 1'b0;
  endtask

  initial
  begin
    step(4);
    rst = 1'b0;
    step(2);
    sc_fast(MODE_100TX, 20, 24, 24);
    sc_fast(MODE_100FX, 10, 14, 14);
    sc_slow(MODE_10T_MII, MII10_HALF_NS / CLK_NS);
    sc_slow(MODE_10T_SER, SER_RX_HALF_NS / CLK_NS);
    sc_tx(MODE_10T_MII, 1'b1);
    sc_tx(MODE_10T_SER, 1'b0);
    sc_park(MODE_10T_MII, 1'b0);
    sc_park(MODE_10T_SER, 1'b1);
    stop_test();
  end
endmodule
